//--- jtag_debug_assertions.sv
/*
 * Checker of the program and debug port, system clock side.
 * Assumes it is bound to the top module and sees only its ports.
 */
module jtag_debug_checker
(
   // system clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_n,
   // layer select and bus
   input wire logic        native_en,
   input wire logic        jtag_active,
   input wire logic        clk_src_native,
   input wire logic        bus_req,
   input wire logic [31:0] bus_addr,
   input wire logic        bus_ack,
   // status
   input wire logic        prog_mode,
   input wire logic        nvm_ctrl_en,
   input wire logic        nvm_unlocked,
   input wire logic        link_tx_mode,
   input wire logic        link_error,
   input wire logic        dev_reset
);
   import prog_debug_pkg::*;
   logic [2:0] nat_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // count of cycles the native layer has been requested
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         nat_q <= 3'h0;
      else
         nat_q <= !native_en ? 3'h0 : (nat_q == 3'h7 ? nat_q : nat_q + 3'h1);

   a_bus_hold: assert property (
      bus_req && !bus_ack && !native_en && !clk_src_native
      |=> (bus_req && $stable(bus_addr)) || link_error)
      else $error("bus request dropped before ack");
   a_bus_release: assert property (bus_req && bus_ack |=> !bus_req)
      else $error("bus request held after ack");
   a_bus_gate: assert property (
      bus_req |-> bus_addr < NVM_BASE || (nvm_unlocked && prog_mode && nvm_ctrl_en))
      else $error("memory read while locked");
   a_err_quiet: assert property (
      link_error && $past(link_error) |-> !bus_req && !link_tx_mode)
      else $error("work continues in error state");
   a_native_prio: assert property (
      nat_q >= 3'h5 |-> !jtag_active && clk_src_native)
      else $error("native layer not taking over");
   a_unlock_ctx: assert property (
      $rose(nvm_unlocked) |-> jtag_active && !link_error && !link_tx_mode)
      else $error("unlock outside key reception");
   a_reset_ctx: assert property ($rose(dev_reset) |-> jtag_active && !link_error)
      else $error("device reset without command");
   a_bus_tx: assert property (bus_req && $past(bus_req) |-> link_tx_mode)
      else $error("bus read outside load answer");
   a_idle_quiet: assert property (
      !jtag_active && !$past(jtag_active) |-> !bus_req && !link_tx_mode)
      else $error("activity while controller off");
endmodule

bind jtag_program_debug_access jtag_debug_checker u_chk (.ref_clk, .rst_n, .native_en,
   .jtag_active, .clk_src_native, .bus_req, .bus_addr, .bus_ack, .prog_mode,
   .nvm_ctrl_en, .nvm_unlocked, .link_tx_mode, .link_error, .dev_reset);

//--- jtag_program_debug_access.sv
/*
 * JTAG physical layer and byte controller of the program and debug port.
 * Assumes tck from the programmer, ref_clk at 10 MHz, and an internal
 * access bus that holds its byte on bus_rdata while bus_ack is high.
 */
module jtag_program_debug_access
(
   // system clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   // jtag pins
   input  wire logic                      tck,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output logic                           tdo,
   output logic                           tdo_oe,
   // physical layer selection
   input  wire logic                      native_en,
   output logic                           jtag_active,
   output logic                           clk_src_native,
   // internal access bus
   output logic                           bus_req,
   output logic [31:0]                    bus_addr,
   input  wire logic                      bus_ack,
   input  wire logic [7:0]                bus_rdata,
   // nonvolatile memory gating
   input  wire logic                      prog_mode,
   input  wire logic                      nvm_ctrl_en,
   output logic                           nvm_unlocked,
   // controller status
   output logic                           link_tx_mode,
   output logic                           link_error,
   output logic                           dev_reset
);
   import prog_debug_pkg::*;

   // link clock domain
   tap_state_t          tap_st;
   logic [IR_W-1:0]     ir_sh_q;
   logic [IR_W-1:0]     ir_q;
   logic [FRAME_W-1:0]  dr_q;
   logic                byp_q;
   logic [3:0]          bit_cnt_q;
   logic [FRAME_W-1:0]  rx_hold_q;
   logic                rx_tog_q;
   logic                ack_q;
   logic                tdo_q;
   logic                tdo_oe_q;
   logic                txm_s1_q;
   logic                txm_s2_q;
   logic                req_s1_q;
   logic                req_s2_q;
   logic                comm_sel;

   // system clock domain
   logic                rx_s1_q;
   logic                rx_s2_q;
   logic                rx_s3_q;
   logic                com_s1_q;
   logic                com_s2_q;
   logic                nat_s1_q;
   logic                nat_s2_q;
   logic                ack_s1_q;
   logic                ack_s2_q;
   ctl_state_t          st_q;
   logic [7:0]          opc_q;
   logic [3:0]          cnt_q;
   logic [2:0]          idx_q;
   logic [2:0]          dsz_q;
   logic [31:0]         addr_q;
   logic [63:0]         key_q;
   logic                nvm_ok_q;
   logic                rst_reg_q;
   logic                tx_req_q;
   logic [7:0]          tx_data_q;
   logic                bus_req_q;
   logic [31:0]         bus_addr_q;
   logic                txm_q;
   logic                clk_nat_q;
   logic                drain_q;
   logic                rx_evt;
   logic                perr;
   logic                abort;
   logic                byte_ok;
   logic                jtag_on;
   logic [7:0]          rx_byte;
   logic [31:0]         cur_addr;
   logic                blocked;
   logic [63:0]         key_next;

   tap_ctrl u_tap
   (
      .tck   (tck),
      .rst_n (rst_n),
      .tms   (tms),
      .state (tap_st)
   );

   assign comm_sel = (ir_q == COMM_IR);

   // instruction register capture, shift and update
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ir_sh_q <= IR_CAPT_VAL;
         ir_q    <= IR_BYPASS;
      end
      else
      begin
         if (tap_st == TAP_CAP_IR)
            ir_sh_q <= IR_CAPT_VAL;
         else if (tap_st == TAP_SH_IR)
            ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
         if (tap_st == TAP_RESET)
            ir_q <= IR_BYPASS;
         else if (tap_st == TAP_UPD_IR)
            ir_q <= ir_sh_q;
      end
   end

   // mode and transmit request from the system domain
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txm_s1_q <= 1'b0;
         txm_s2_q <= 1'b0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
      end
      else
      begin
         txm_s1_q <= txm_q;
         txm_s2_q <= txm_s1_q;
         req_s1_q <= tx_req_q;
         req_s2_q <= req_s1_q;
      end
   end

   // communication register: load at capture, shift lsb first
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
         dr_q <= NO_PEND_FRM;
      else if (tap_st == TAP_CAP_DR)
      begin
         if (!txm_s2_q)
            dr_q <= special_frame(NO_PEND);
         else if (req_s2_q != ack_q)
            dr_q <= good_frame(tx_data_q);
         else
            dr_q <= special_frame(NOT_READY);
      end
      else if (tap_st == TAP_SH_DR && comm_sel)
         dr_q <= {tdi, dr_q[FRAME_W-1:1]};
   end

   // acknowledge: a capture consumes any offered byte; stale offers drop
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
         ack_q <= 1'b0;
      else if (tap_st == TAP_CAP_DR && comm_sel)
         ack_q <= req_s2_q;
   end

   // bypass bit and shifted bit count
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         byp_q     <= 1'b0;
         bit_cnt_q <= 4'h0;
      end
      else if (tap_st == TAP_CAP_DR)
      begin
         byp_q     <= 1'b0;
         bit_cnt_q <= 4'h0;
      end
      else if (tap_st == TAP_SH_DR)
      begin
         byp_q <= tdi;
         if (bit_cnt_q != 4'hF)
            bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // complete frames handed to the controller at update dr
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_hold_q <= '0;
         rx_tog_q  <= 1'b0;
      end
      else if (tap_st == TAP_UPD_DR && comm_sel && bit_cnt_q == 4'(FRAME_W))
      begin
         rx_hold_q <= dr_q;
         rx_tog_q  <= ~rx_tog_q;
      end
   end

   // tdo launched on falling tck
   always_ff @(negedge tck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else
      begin
         tdo_oe_q <= (tap_st == TAP_SH_DR) || (tap_st == TAP_SH_IR);
         if (tap_st == TAP_SH_IR)
            tdo_q <= ir_sh_q[0];
         else if (tap_st == TAP_SH_DR)
            tdo_q <= comm_sel ? dr_q[0] : byp_q;
         else
            tdo_q <= 1'b0;
      end
   end

   assign tdo    = tdo_q;
   assign tdo_oe = tdo_oe_q;

   // synchronisers into the system domain
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_s1_q  <= 1'b0;
         rx_s2_q  <= 1'b0;
         rx_s3_q  <= 1'b0;
         com_s1_q <= 1'b0;
         com_s2_q <= 1'b0;
         nat_s1_q <= 1'b0;
         nat_s2_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end
      else
      begin
         rx_s1_q  <= rx_tog_q;
         rx_s2_q  <= rx_s1_q;
         rx_s3_q  <= rx_s2_q;
         com_s1_q <= comm_sel;
         com_s2_q <= com_s1_q;
         nat_s1_q <= native_en;
         nat_s2_q <= nat_s1_q;
         ack_s1_q <= ack_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // frame checks on the held frame
   assign rx_evt   = rx_s2_q ^ rx_s3_q;
   assign rx_byte  = rx_hold_q[7:0];
   assign perr     = ^rx_hold_q;
   assign abort    = perr && (rx_byte == ABORT_CHAR);
   assign byte_ok  = rx_evt && !perr;
   assign jtag_on  = com_s2_q && !nat_s2_q;
   assign cur_addr = addr_q + {29'h0, idx_q};
   assign blocked  = (cur_addr >= NVM_BASE) &&
                     !(nvm_ok_q && prog_mode && nvm_ctrl_en);
   assign key_next = {rx_byte, key_q[63:8]};

   // controller sequence: decode, operands, reads, answers, errors
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q       <= CTL_OFF;
         opc_q      <= 8'h00;
         cnt_q      <= 4'h0;
         idx_q      <= 3'h0;
         dsz_q      <= 3'h0;
         addr_q     <= 32'h0000_0000;
         tx_req_q   <= 1'b0;
         tx_data_q  <= 8'h00;
         bus_req_q  <= 1'b0;
         bus_addr_q <= 32'h0000_0000;
      end
      else if (!jtag_on)
      begin
         st_q      <= CTL_OFF;
         bus_req_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            CTL_OFF:
            begin
               st_q   <= CTL_IDLE;
               opc_q  <= 8'h00;
               cnt_q  <= 4'h0;
               idx_q  <= 3'h0;
               addr_q <= 32'h0000_0000;
            end
            CTL_IDLE:
               if (rx_evt && perr)
                  st_q <= CTL_ERROR;
               else if (byte_ok && !drain_q)
               begin
                  opc_q <= rx_byte;
                  idx_q <= 3'h0;
                  case (rx_byte[7:5])
                     OP_LOAD_DIR:
                     begin
                        cnt_q <= {2'b00, rx_byte[3:2]} + 4'h1;
                        dsz_q <= {1'b0, rx_byte[1:0]} + 3'h1;
                        st_q  <= CTL_OPER;
                     end
                     OP_KEY:
                     begin
                        cnt_q <= KEY_BYTES;
                        st_q  <= CTL_OPER;
                     end
                     OP_RST_REG:
                     begin
                        cnt_q <= 4'h1;
                        st_q  <= CTL_OPER;
                     end
                     default:
                        st_q <= CTL_IDLE;
                  endcase
               end
            CTL_OPER:
               if (rx_evt && perr)
                  st_q <= CTL_ERROR;
               else if (byte_ok)
               begin
                  if (opc_q[7:5] == OP_LOAD_DIR)
                     addr_q[{idx_q[1:0], 3'b000} +: 8] <= rx_byte;
                  idx_q <= idx_q + 3'h1;
                  cnt_q <= cnt_q - 4'h1;
                  if (cnt_q == 4'h1)
                  begin
                     idx_q <= 3'h0;
                     st_q  <= (opc_q[7:5] == OP_LOAD_DIR) ? CTL_FETCH : CTL_IDLE;
                  end
               end
            CTL_FETCH:
               if (rx_evt && perr)
               begin
                  st_q      <= CTL_ERROR;
                  bus_req_q <= 1'b0;
               end
               else if (blocked)
               begin
                  tx_data_q <= BLOCKED_RD;
                  tx_req_q  <= ~tx_req_q;
                  st_q      <= CTL_SEND;
               end
               else if (!bus_req_q)
               begin
                  bus_req_q  <= 1'b1;       // single-byte access
                  bus_addr_q <= cur_addr;
               end
               else if (bus_ack)
               begin
                  bus_req_q <= 1'b0;
                  tx_data_q <= bus_rdata;
                  tx_req_q  <= ~tx_req_q;   // offer byte to the link
                  st_q      <= CTL_SEND;
               end
            CTL_SEND:
               if (rx_evt && perr)
                  st_q <= CTL_ERROR;
               else if (ack_s2_q == tx_req_q)
               begin
                  if (idx_q == dsz_q - 3'h1)
                     st_q <= CTL_IDLE;
                  else
                  begin
                     idx_q <= idx_q + 3'h1;
                     st_q  <= CTL_FETCH;
                  end
               end
            CTL_ERROR:
               if (rx_evt && abort)
                  st_q <= CTL_IDLE;
            default:
               st_q <= CTL_OFF;
         endcase
      end
   end

   // dummy frame that carried the last answer is still to arrive: swallow it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         drain_q <= 1'b0;
      else if (jtag_on && st_q == CTL_SEND && ack_s2_q == tx_req_q &&
               idx_q == dsz_q - 3'h1 && !(rx_evt && perr))
         drain_q <= 1'b1;
      else if (rx_evt || st_q == CTL_OFF)
         drain_q <= 1'b0;
   end

   // unlock key collection and comparison
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_q    <= 64'h0000_0000_0000_0000;
         nvm_ok_q <= 1'b0;
      end
      else if (st_q == CTL_OFF)
      begin
         key_q    <= 64'h0000_0000_0000_0000;
         nvm_ok_q <= 1'b0;
      end
      else if (st_q == CTL_OPER && byte_ok && opc_q[7:5] == OP_KEY)
      begin
         key_q <= key_next;
         if (cnt_q == 4'h1)
            nvm_ok_q <= (key_next == UNLOCK_KEY);
      end
   end

   // reset register, held until written back to zero or the controller turns off
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_reg_q <= 1'b0;
      else if (st_q == CTL_OFF)
         rst_reg_q <= 1'b0;
      else if (st_q == CTL_OPER && byte_ok && opc_q[7:5] == OP_RST_REG)
         rst_reg_q <= (rx_byte != 8'h00);
   end

   // direction and clock source status
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txm_q     <= 1'b0;
         clk_nat_q <= 1'b0;
      end
      else
      begin
         txm_q     <= (st_q == CTL_FETCH) || (st_q == CTL_SEND);
         clk_nat_q <= nat_s2_q;
      end
   end

   assign jtag_active    = (st_q != CTL_OFF);
   assign clk_src_native = clk_nat_q;
   assign bus_req        = bus_req_q;
   assign bus_addr       = bus_addr_q;
   assign nvm_unlocked   = nvm_ok_q;
   assign link_tx_mode   = txm_q;
   assign link_error     = (st_q == CTL_ERROR);
   assign dev_reset      = rst_reg_q;

endmodule

//--- jtag_programmer_model.sv
/*
 * Behavioural programmer on the jtag pins, 30 ns tck.
 * Assumes the tap starts in test-logic-reset; tck rests low between scans.
 */
module jtag_programmer_model
(
   // jtag pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one tck cycle: change on falling, sample tdo on rising
   task automatic tick(input logic t, input logic d, output logic q);
      tms = t;
      tdi = d;
      #15 tck = 1'b1;
      q = tdo;
      #15 tck = 1'b0;
   endtask

   // load the instruction register from run-test-idle path
   task automatic ir_load(input logic [3:0] ir);
      logic q;
      for (int i = 0; i < 5; i++)
         tick(5'b00110 >> i, ~tdi, q);
      for (int i = 0; i < 4; i++)
         tick(i == 3, ir[i], q);
      tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
   endtask

   // one 9-bit frame, bit 0 first, then idle spacing
   task automatic frame(input logic [8:0] d, output logic [8:0] q);
      logic x;
      tick(1'b1, ~tdi, x);
      tick(1'b0, ~tdi, x);
      tick(1'b0, ~tdi, x);
      for (int i = 0; i < 9; i++)
         tick(i == 8, d[i], q[i]);
      tick(1'b1, ~tdi, x);
      tick(1'b0, ~tdi, x);
      #400;
   endtask
endmodule

//--- prog_debug_pkg.sv
/*
 * Shared constants and types for the JTAG program and debug access port.
 * Assumes a 9-bit frame, an 8-bit byte path and a 32-bit internal address.
 */
package prog_debug_pkg;

   // frame and character layout
   localparam int          FRAME_W     = 9;
   localparam logic [7:0]  ABORT_CHAR  = 8'hBB;
   localparam logic [7:0]  NOT_READY   = 8'hDB;
   localparam logic [7:0]  NO_PEND     = 8'hEB;
   localparam logic [8:0]  NO_PEND_FRM = 9'h1EB;   // no-pending with inverted parity
   localparam logic [63:0] UNLOCK_KEY  = 64'h1289_AB45_CDD8_88FF;
   localparam logic [3:0]  KEY_BYTES   = 4'h8;

   // jtag instruction register
   localparam int          IR_W        = 4;
   localparam logic [3:0]  IR_CAPT_VAL = 4'h1;
   localparam logic [3:0]  IR_BYPASS   = 4'hF;
   localparam logic [3:0]  COMM_IR     = 4'h7;

   // byte instruction opcodes in bits 7:5
   localparam logic [2:0]  OP_LOAD_DIR = 3'h0;
   localparam logic [2:0]  OP_RST_REG  = 3'h6;
   localparam logic [2:0]  OP_KEY      = 3'h7;

   // internal address map and blocked read answer
   localparam logic [31:0] NVM_BASE    = 32'h0100_0000;
   localparam logic [7:0]  BLOCKED_RD  = 8'h00;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
      TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } tap_state_t;

   typedef enum logic [2:0] {
      CTL_OFF, CTL_IDLE, CTL_OPER, CTL_FETCH, CTL_SEND, CTL_ERROR
   } ctl_state_t;

   // normal frame: data with even parity
   function automatic logic [8:0] good_frame(input logic [7:0] b);
      good_frame = {^b, b};
   endfunction

   // special frame: data with inverted parity
   function automatic logic [8:0] special_frame(input logic [7:0] b);
      special_frame = {~^b, b};
   endfunction

endpackage

//--- tap_ctrl.sv
/*
 * IEEE 1149.1 test access port state machine, clocked by tck.
 * Assumes tms is driven by the programmer, stable around rising tck.
 */
module tap_ctrl
(
   // link clock and reset
   input  wire logic                      tck,
   input  wire logic                      rst_n,
   // mode select pin
   input  wire logic                      tms,
   // current tap state
   output prog_debug_pkg::tap_state_t     state
);
   import prog_debug_pkg::*;

   tap_state_t st_q;
   tap_state_t st_d;

   // next state from tms
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         TAP_RESET:  st_d = tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   st_d = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: st_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: st_d = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  st_d = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: st_d = tms ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR:  st_d = tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: st_d = tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: st_d = tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: st_d = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  st_d = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: st_d = tms ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR:  st_d = tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: st_d = tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
         default:    st_d = TAP_RESET;
      endcase
   end

   // state register on rising tck
   always_ff @(posedge tck or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= TAP_RESET;
      else
         st_q <= st_d;
   end

   assign state = st_q;

endmodule

//--- testbench.sv
/*
 * Self-checking bench of the program and debug port with a bus responder.
 * Assumes the programmer model on the jtag pins and 10 MHz ref_clk.
 */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import prog_debug_pkg::*;
   logic        ref_clk = 1'b0, rst_n = 1'b0, native_en = 1'b0, bus_ack = 1'b0;
   logic        prog_mode = 1'b1, nvm_ctrl_en = 1'b1, keyed = 1'b0;
   logic [7:0]  bus_rdata = 8'h00, b;
   logic        tck, tms, tdi, tdo, tdo_oe, jtag_active, clk_src_native;
   logic        bus_req, nvm_unlocked, link_tx_mode, link_error, dev_reset;
   logic [31:0] bus_addr, exp_addr, addr_m = 32'h0;
   logic [8:0]  last_q;
   logic [7:0]  exp_q[$];
   int          mismatches = 0, checked = 0, seed = 85, lat = 0, oe_cnt = 0;

   always #50 ref_clk = ~ref_clk;

   // count rising tck edges that see tdo driven
   always @(posedge tck)
      if (tdo_oe === 1'b1)
         oe_cnt++;

   jtag_program_debug_access u_dut (.ref_clk, .rst_n, .tck, .tms, .tdi, .tdo, .tdo_oe,
      .native_en, .jtag_active, .clk_src_native, .bus_req, .bus_addr, .bus_ack,
      .bus_rdata, .prog_mode, .nvm_ctrl_en, .nvm_unlocked, .link_tx_mode, .link_error,
      .dev_reset);
   jtag_programmer_model u_prog (.tck, .tms, .tdi, .tdo);

   // bus responder: random latency and data, byte queued for the model
   always @(posedge ref_clk)
   begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack)
         if (lat == 0)
         begin
            b = $random(seed);
            bus_ack <= 1'b1;
            bus_rdata <= b;
            exp_q.push_back(b);
            `CHK(bus_addr, exp_addr)
            exp_addr++;
            lat <= $random(seed) & 7;
         end
         else
            lat <= lat - 1;
   end

   task automatic send(input logic [7:0] v);
      int k;
      k = oe_cnt;
      u_prog.frame({^v, v}, last_q);
      `CHK(oe_cnt - k, 9)
   endtask

   task automatic send_abort;
      u_prog.frame({~^ABORT_CHAR, ABORT_CHAR}, last_q);
   endtask

   // direct load with model of pointer and answers
   task automatic load(input int asz, input int dsz, input logic [31:0] a);
      logic [7:0] e;
      logic       blk;
      int         n;
      send(8'((asz - 1) * 4 + dsz - 1));
      for (int i = 0; i < asz; i++)
      begin
         send(a[8 * i +: 8]);
         addr_m[8 * i +: 8] = a[8 * i +: 8];
      end
      exp_addr = addr_m;
      blk = addr_m >= NVM_BASE && !(keyed && prog_mode && nvm_ctrl_en);
      `CHK(link_tx_mode, 1'b1)
      n = 0;
      for (int t = 0; t < 60 && n < dsz; t++)
      begin
         u_prog.frame(9'h000, last_q);
         if (last_q[8] !== ^last_q[7:0])
            `CHK(last_q[7:0] == NOT_READY || last_q[7:0] == NO_PEND, 1'b1)
         else
         begin
            e = blk ? BLOCKED_RD : exp_q.pop_front();
            `CHK(last_q, {^e, e})
            n++;
         end
      end
      `CHK(n, dsz)
      `CHK(link_tx_mode, 1'b0)
   endtask

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #2_000_000;
      mismatches++;
      end_of_test;
   end

   initial
   begin
      repeat (8) @(posedge ref_clk);
      `CHK(jtag_active, 1'b0)
      rst_n <= 1'b1;
      u_prog.ir_load(COMM_IR);
      for (int i = 0; i < 20 && jtag_active !== 1'b1; i++)
         @(posedge ref_clk);
      `CHK(jtag_active, 1'b1)
      send(8'hC0);
      `CHK(last_q, {~^NO_PEND, NO_PEND})
      send(8'h01);
      `CHK(dev_reset, 1'b1)
      send(8'hC0);
      send(8'h00);
      `CHK(dev_reset, 1'b0)
      load(4, 1, NVM_BASE);
      `CHK(nvm_unlocked, 1'b0)
      send(8'hE0);
      for (int i = 0; i < 8; i++)
         send(UNLOCK_KEY[8 * i +: 8]);
      `CHK(nvm_unlocked, 1'b1)
      keyed = 1'b1;
      load(4, 1, NVM_BASE);
      @(posedge ref_clk);
      prog_mode <= 1'b0;
      load(4, 1, NVM_BASE);
      @(posedge ref_clk);
      prog_mode <= 1'b1;
      nvm_ctrl_en <= 1'b0;
      load(4, 1, NVM_BASE);
      @(posedge ref_clk);
      nvm_ctrl_en <= 1'b1;
      for (int k = 0; k < 4; k++)
         load(4 - k, k + 1, $random(seed) & 32'h00FF_FFF0);
      u_prog.frame(9'h13C, last_q);
      `CHK(link_error, 1'b1)
      send(8'h00);
      `CHK(link_error, 1'b1)
      send_abort;
      `CHK(link_error, 1'b0)
      addr_m[7:0] = 8'h10;
      exp_addr = addr_m;
      send(8'h00);
      send(8'h10);
      u_prog.frame(9'h100, last_q);
      `CHK(link_error, 1'b1)
      send_abort;
      addr_m[7:0] = 8'h20;
      exp_addr = addr_m;
      send(8'h00);
      send(8'h20);
      send_abort;
      send_abort;
      `CHK(link_error, 1'b0)
      `CHK(link_tx_mode, 1'b0)
      exp_q.delete();
      @(posedge ref_clk);
      native_en <= 1'b1;
      repeat (10) @(posedge ref_clk);
      `CHK(clk_src_native, 1'b1)
      `CHK(jtag_active, 1'b0)
      native_en <= 1'b0;
      repeat (10) @(posedge ref_clk);
      `CHK(jtag_active, 1'b1)
      `CHK(nvm_unlocked, 1'b0)
      end_of_test;
   end
endmodule
